// ---- core/status_pkg.sv ----
package status_pkg;
    // =====================================================
    // Widths
    localparam int BYTE_W = 8;
    localparam int QUES_W = 16;
    localparam int OPER_W = 16;
    localparam int ESR_W  = 8;

    // =====================================================
    // Status byte bit positions
    localparam int BIT_ERRQ      = 2;
    localparam int BIT_QUES      = 3;
    localparam int BIT_MSG_AVAIL = 4;
    localparam int BIT_EVT_SUM   = 5;
    localparam int BIT_MASTER    = 6;
    localparam int BIT_OPER      = 7;

    // =====================================================
    // Masks and reset values
    localparam logic [7:0] UNUSED_BITS = 8'h03;
    localparam logic [7:0] SRQ_IGNORE  = 8'h40;
    localparam logic [7:0] SUMMARY_BYTE_RESET = 8'h00;
    localparam logic [7:0] REQ_MASK_RESET     = 8'h00;
    localparam logic [7:0] POLL_MASK_RESET    = 8'h00;
    localparam logic [7:0] RSP_RESET          = 8'h00;

    // =====================================================
    // Command codes
    typedef enum logic [2:0] {
        CMD_BYTE_QUERY      = 3'h0,
        CMD_REQ_MASK_SET    = 3'h1,
        CMD_REQ_MASK_QUERY  = 3'h2,
        CMD_POLL_MASK_SET   = 3'h3,
        CMD_POLL_MASK_QUERY = 3'h4,
        CMD_FLAG_QUERY      = 3'h5
    } cmd_t;
endpackage

// ---- core/sum_reduce.sv ----
`timescale 1ns/1ps
module sum_reduce #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] event_bits,
    input  wire logic [W-1:0] enable_bits,
    output logic              sum_bit
);
    logic [W-1:0] gated;

    // =====================================================
    // Per-bit gating, then OR into one summary
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign gated[i] = event_bits[i] & enable_bits[i];
        end
    endgenerate

    assign sum_bit = |gated;
endmodule

// ---- core/rise_detect.sv ----
`timescale 1ns/1ps
module rise_detect #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] level,
    output logic [W-1:0]      rise
);
    logic [W-1:0] prev_ff;

    // =====================================================
    // Per-bit 0 to 1 detection
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!rst_b) begin
                    prev_ff[i] <= 1'b0;
                end else begin
                    prev_ff[i] <= level[i];
                end
            end
            assign rise[i] = level[i] & ~prev_ff[i];
        end
    endgenerate
endmodule

// ---- core/status_byte_service_request.sv ----
// Behaviour
// - Bit 6 is master summary of the other enabled status byte bits.
// - Every byte bit has a request mask bit; mask bit 6 is ignored.
// - An enabled status byte bit rising 0 to 1 issues a service request.
// - Status byte query and serial poll both return the current status byte.
// - Bit 2 is set when an error queue entry is placed.
// - With mask bit 2 set, every new error entry issues a request.
// - Bit 3 is the questionable register enabled-event summary.
// - Bit 4 is set while the output buffer holds a readable message.
// - Bit 5 is the standard event register enabled summary.
// - Bit 7 is the operation register enabled-event summary.
// - Individual status is OR of status byte bits ANDed with poll mask.
// - Poll mask includes bit 6, so master summary feeds individual status.
// - Individual status returned by parallel poll and by its query.
// - Request mask is written by set command and read back by query.
// - Poll mask is written by set command and read back by query.
// - Lower registers form summary bits from event and enable parts.
`timescale 1ns/1ps
module status_byte_service_request (
    input  wire logic                         SYS_CLK,
    input  wire logic                         RST_B,
    input  wire logic [status_pkg::QUES_W-1:0] QUES_EVENT,
    input  wire logic [status_pkg::QUES_W-1:0] QUES_ENABLE,
    input  wire logic [status_pkg::OPER_W-1:0] OPER_EVENT,
    input  wire logic [status_pkg::OPER_W-1:0] OPER_ENABLE,
    input  wire logic [status_pkg::ESR_W-1:0]  ESR_EVENT,
    input  wire logic [status_pkg::ESR_W-1:0]  ESE_MASK,
    input  wire logic                         ERRQ_NOT_EMPTY,
    input  wire logic                         ERRQ_PUSH,
    input  wire logic                         OUTBUF_AVAIL,
    input  wire logic                         CMD_VALID,
    input  wire logic [2:0]                   CMD_CODE,
    input  wire logic [status_pkg::BYTE_W-1:0] CMD_DATA,
    input  wire logic                         SPOLL_REQ,
    input  wire logic                         PPOLL_REQ,
    output logic                              RSP_VALID,
    output logic [status_pkg::BYTE_W-1:0]     RSP_DATA,
    output logic                              SPOLL_VALID,
    output logic [status_pkg::BYTE_W-1:0]     SPOLL_BYTE,
    output logic                              PPOLL_VALID,
    output logic                              PPOLL_FLAG,
    output logic                              STATUS_FLAG,
    output logic                              SRQ_PULSE
);
    logic [7:0] summary_ff;
    logic [7:0] nxt_summary;
    logic [7:0] req_mask_ff;
    logic [7:0] poll_mask_ff;
    logic       flag_ff;
    logic       nxt_flag;
    logic       err_push_ff;
    logic       nxt_srq;
    logic [7:0] srq_enabled;
    logic [7:0] srq_rise;
    logic       ques_sum;
    logic       oper_sum;
    logic       esr_sum;
    logic       is_cmd;
    logic       past_ok_ff;

    // =====================================================
    // Lower register summaries
    sum_reduce #(.W(status_pkg::QUES_W)) u_ques_sum (
        .event_bits  (QUES_EVENT),
        .enable_bits (QUES_ENABLE),
        .sum_bit     (ques_sum)
    );

    sum_reduce #(.W(status_pkg::OPER_W)) u_oper_sum (
        .event_bits  (OPER_EVENT),
        .enable_bits (OPER_ENABLE),
        .sum_bit     (oper_sum)
    );

    sum_reduce #(.W(status_pkg::ESR_W)) u_esr_sum (
        .event_bits  (ESR_EVENT),
        .enable_bits (ESE_MASK),
        .sum_bit     (esr_sum)
    );

    // =====================================================
    // Status byte assembly
    always_comb begin
        nxt_summary                           = status_pkg::SUMMARY_BYTE_RESET;
        nxt_summary[status_pkg::BIT_ERRQ]      = ERRQ_NOT_EMPTY | ERRQ_PUSH;
        nxt_summary[status_pkg::BIT_QUES]      = ques_sum;
        nxt_summary[status_pkg::BIT_MSG_AVAIL] = OUTBUF_AVAIL;
        nxt_summary[status_pkg::BIT_EVT_SUM]   = esr_sum;
        nxt_summary[status_pkg::BIT_OPER]      = oper_sum;
        nxt_summary[status_pkg::BIT_MASTER]    = |(nxt_summary & req_mask_ff & ~status_pkg::SRQ_IGNORE);
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            summary_ff <= status_pkg::SUMMARY_BYTE_RESET;
        end else begin
            summary_ff <= nxt_summary;
        end
    end

    // =====================================================
    // Individual status flag
    assign nxt_flag = |(summary_ff & poll_mask_ff & ~status_pkg::UNUSED_BITS);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            flag_ff <= 1'b0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    assign STATUS_FLAG = flag_ff;

    // =====================================================
    // Service request generation
    assign srq_enabled = summary_ff & req_mask_ff & ~status_pkg::SRQ_IGNORE & ~status_pkg::UNUSED_BITS;

    rise_detect #(.W(status_pkg::BYTE_W)) u_srq_rise (
        .clk   (SYS_CLK),
        .rst_b (RST_B),
        .level (srq_enabled),
        .rise  (srq_rise)
    );

    assign nxt_srq = (|srq_rise) | (err_push_ff & req_mask_ff[status_pkg::BIT_ERRQ]);

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            err_push_ff <= 1'b0;
            SRQ_PULSE   <= 1'b0;
        end else begin
            err_push_ff <= ERRQ_PUSH;
            SRQ_PULSE   <= nxt_srq;
        end
    end

    // =====================================================
    // Mask registers
    assign is_cmd = CMD_VALID;

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            req_mask_ff <= status_pkg::REQ_MASK_RESET;
        end else if (is_cmd && CMD_CODE == status_pkg::CMD_REQ_MASK_SET) begin
            req_mask_ff <= CMD_DATA;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            poll_mask_ff <= status_pkg::POLL_MASK_RESET;
        end else if (is_cmd && CMD_CODE == status_pkg::CMD_POLL_MASK_SET) begin
            poll_mask_ff <= CMD_DATA;
        end
    end

    // =====================================================
    // Query answers
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            RSP_VALID <= 1'b0;
            RSP_DATA  <= status_pkg::RSP_RESET;
        end else begin
            RSP_VALID <= 1'b0;
            if (is_cmd) begin
                case (CMD_CODE)
                    status_pkg::CMD_BYTE_QUERY: begin
                        RSP_VALID <= 1'b1;
                        RSP_DATA  <= summary_ff;
                    end
                    status_pkg::CMD_REQ_MASK_QUERY: begin
                        RSP_VALID <= 1'b1;
                        RSP_DATA  <= req_mask_ff;
                    end
                    status_pkg::CMD_POLL_MASK_QUERY: begin
                        RSP_VALID <= 1'b1;
                        RSP_DATA  <= poll_mask_ff;
                    end
                    status_pkg::CMD_FLAG_QUERY: begin
                        RSP_VALID <= 1'b1;
                        RSP_DATA  <= {7'h00, flag_ff};
                    end
                    default: begin
                        RSP_VALID <= 1'b0;
                    end
                endcase
            end
        end
    end

    // =====================================================
    // Serial and parallel poll
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            SPOLL_VALID <= 1'b0;
            SPOLL_BYTE  <= status_pkg::SUMMARY_BYTE_RESET;
        end else begin
            SPOLL_VALID <= SPOLL_REQ;
            if (SPOLL_REQ) begin
                SPOLL_BYTE <= summary_ff;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            PPOLL_VALID <= 1'b0;
            PPOLL_FLAG  <= 1'b0;
        end else begin
            PPOLL_VALID <= PPOLL_REQ;
            if (PPOLL_REQ) begin
                PPOLL_FLAG <= flag_ff;
            end
        end
    end

    // =====================================================
    // Checks
    always_ff @(posedge SYS_CLK) begin
        if (!RST_B) begin
            past_ok_ff <= 1'b0;
        end else begin
            past_ok_ff <= 1'b1;
        end
    end

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RST_B);

    sequence s_cmd(logic [2:0] code);
        CMD_VALID && CMD_CODE == code;
    endsequence

    sequence s_req_mask_write_query;
        s_cmd(status_pkg::CMD_REQ_MASK_SET) ##1 s_cmd(status_pkg::CMD_REQ_MASK_QUERY);
    endsequence

    sequence s_poll_mask_write_query;
        s_cmd(status_pkg::CMD_POLL_MASK_SET) ##1 s_cmd(status_pkg::CMD_POLL_MASK_QUERY);
    endsequence

    // Only mask bit 6 set among the bits that can matter
    sequence s_only_mask6;
        (req_mask_ff & ~status_pkg::UNUSED_BITS) == status_pkg::SRQ_IGNORE;
    endsequence

    a_master_summary: assert property (
        past_ok_ff |-> summary_ff[6] == |(summary_ff & $past(req_mask_ff) & ~status_pkg::SRQ_IGNORE))
        else $error("master summary bit mismatch");

    a_mask6_ignored: assert property (
        s_only_mask6 ##1 s_only_mask6 |-> !summary_ff[6] && !SRQ_PULSE)
        else $error("mask bit 6 contributed to request");

    a_srq_on_rise: assert property (
        past_ok_ff && (srq_enabled & ~$past(srq_enabled)) != 8'h00 |=> SRQ_PULSE)
        else $error("enabled rise gave no service request");

    a_srq_cause: assert property (
        SRQ_PULSE |-> $past(srq_rise != 8'h00 || (err_push_ff && req_mask_ff[2])))
        else $error("service request without cause");

    a_byte_query: assert property (
        s_cmd(status_pkg::CMD_BYTE_QUERY) |=> RSP_VALID && RSP_DATA == $past(summary_ff))
        else $error("status byte query answer wrong");

    a_spoll_byte: assert property (
        SPOLL_REQ |=> SPOLL_VALID && SPOLL_BYTE == $past(summary_ff))
        else $error("serial poll byte wrong");

    a_errq_bit: assert property (
        ERRQ_PUSH |=> summary_ff[2])
        else $error("error queue bit not set");

    a_errq_each_srq: assert property (
        ERRQ_PUSH ##1 (req_mask_ff[2] && summary_ff[2]) |=> SRQ_PULSE)
        else $error("error entry gave no service request");

    a_ques_bit: assert property (
        past_ok_ff |-> summary_ff[3] == $past(|(QUES_EVENT & QUES_ENABLE)))
        else $error("questionable summary wrong");

    a_msg_avail_bit: assert property (
        past_ok_ff |-> summary_ff[4] == $past(OUTBUF_AVAIL))
        else $error("message available bit wrong");

    a_event_sum_bit: assert property (
        past_ok_ff |-> summary_ff[5] == $past(|(ESR_EVENT & ESE_MASK)))
        else $error("event summary bit wrong");

    a_oper_bit: assert property (
        past_ok_ff |-> summary_ff[7] == $past(|(OPER_EVENT & OPER_ENABLE)))
        else $error("operation summary wrong");

    a_flag_value: assert property (
        past_ok_ff |-> STATUS_FLAG == $past(|(summary_ff & poll_mask_ff)))
        else $error("individual status wrong");

    a_flag_master: assert property (
        (summary_ff[6] && poll_mask_ff == 8'h40) |=> STATUS_FLAG)
        else $error("master summary ignored by poll mask");

    a_ppoll_answer: assert property (
        PPOLL_REQ |=> PPOLL_VALID && PPOLL_FLAG == $past(STATUS_FLAG))
        else $error("parallel poll answer wrong");

    a_req_mask_readback: assert property (
        s_req_mask_write_query |=> RSP_VALID && RSP_DATA == $past(CMD_DATA, 2))
        else $error("request mask readback wrong");

    a_poll_mask_readback: assert property (
        s_poll_mask_write_query |=> RSP_VALID && RSP_DATA == $past(CMD_DATA, 2))
        else $error("poll mask readback wrong");

    a_unused_zero: assert property (
        (summary_ff & status_pkg::UNUSED_BITS) == 8'h00 && (srq_enabled & status_pkg::UNUSED_BITS) == 8'h00)
        else $error("unused bits not zero");
endmodule

// ---- tb/remote_ctl_model.sv ----
`timescale 1ns/1ps
module remote_ctl_model (
    input  wire logic       clk,
    input  wire logic       rsp_valid,
    input  wire logic [7:0] rsp_data,
    input  wire logic       spoll_valid,
    input  wire logic [7:0] spoll_byte,
    input  wire logic       ppoll_valid,
    input  wire logic       ppoll_flag,
    output logic            cmd_valid,
    output logic [2:0]      cmd_code,
    output logic [7:0]      cmd_data,
    output logic            spoll_req,
    output logic            ppoll_req
);
    // ==========================================
    // Idle levels
    initial begin
        cmd_valid = 1'b0;
        cmd_code = 3'h7;
        cmd_data = 8'h00;
        spoll_req = 1'b0;
        ppoll_req = 1'b0;
    end

    // ==========================================
    // Kind 0 query, 1 serial poll, 2 parallel poll, 3 set; called just after an edge
    task automatic ask(input int k, input logic [2:0] c, input logic [7:0] d,
                       output logic [7:0] r, output bit ok);
        ok = (k == 3);
        r = 8'h00;
        cmd_valid <= (k == 0 || k == 3);
        cmd_code <= c;
        cmd_data <= d;
        spoll_req <= (k == 1);
        ppoll_req <= (k == 2);
        @(posedge clk);
        // A set is always followed at once by the caller's next command
        if (k != 3) begin
            cmd_valid <= 1'b0;
            cmd_code <= ~c;
            cmd_data <= ~d;
            spoll_req <= 1'b0;
            ppoll_req <= 1'b0;
        end
        for (int i = 0; i < 5 && !ok; i++) begin
            @(posedge clk);
            ok = (k == 0) ? (rsp_valid === 1'b1) : (k == 1) ? (spoll_valid === 1'b1) : (ppoll_valid === 1'b1);
            r = (k == 0) ? rsp_data : (k == 1) ? spoll_byte : {7'h00, ppoll_flag};
        end
    endtask
endmodule

// ---- tb/test_status_byte_service_request.sv ----
`timescale 1ns/1ps
module test_status_byte_service_request;
    logic        sys_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [15:0] qev = 16'h0000;
    logic [15:0] qen = 16'h0000;
    logic [15:0] oev = 16'h0000;
    logic [15:0] oen = 16'h0000;
    logic [7:0]  esr = 8'h00;
    logic [7:0]  ese = 8'h00;
    logic        errq_ne = 1'b0;
    logic        errq_push = 1'b0;
    logic        outbuf = 1'b0;
    logic        cmd_valid, spoll_req, ppoll_req, rsp_valid, spoll_valid, ppoll_valid, ppoll_flag;
    logic        status_flag, srq_pulse;
    logic [2:0]  cmd_code;
    logic [7:0]  cmd_data, rsp_data, spoll_byte, req_m, poll_m;
    logic [15:0] srq_seen = 16'h0000;
    logic [15:0] d;
    int          fail_count = 0;
    int          comparisons = 0;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (srq_pulse === 1'b1) srq_seen <= srq_seen + 16'h0001;

    status_byte_service_request i_dut (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .QUES_EVENT(qev), .QUES_ENABLE(qen),
        .OPER_EVENT(oev), .OPER_ENABLE(oen), .ESR_EVENT(esr), .ESE_MASK(ese),
        .ERRQ_NOT_EMPTY(errq_ne), .ERRQ_PUSH(errq_push), .OUTBUF_AVAIL(outbuf),
        .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_DATA(cmd_data),
        .SPOLL_REQ(spoll_req), .PPOLL_REQ(ppoll_req), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
        .SPOLL_VALID(spoll_valid), .SPOLL_BYTE(spoll_byte), .PPOLL_VALID(ppoll_valid),
        .PPOLL_FLAG(ppoll_flag), .STATUS_FLAG(status_flag), .SRQ_PULSE(srq_pulse)
    );

    remote_ctl_model i_ctl (
        .clk(sys_clk), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .spoll_valid(spoll_valid),
        .spoll_byte(spoll_byte), .ppoll_valid(ppoll_valid), .ppoll_flag(ppoll_flag),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .spoll_req(spoll_req), .ppoll_req(ppoll_req)
    );

    // ==========================================
    // Expected status byte from the live inputs
    function automatic logic [7:0] exp_byte(input logic [7:0] m);
        logic [7:0] b;
        b = {|(oev & oen), 1'b0, |(esr & ese), outbuf, |(qev & qen), errq_ne, 2'b00};
        b[6] = |(b & m & 8'hbf);
        return b;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim;
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic q(input int k, input logic [2:0] c, input logic [7:0] v, output logic [7:0] r);
        bit ok;
        i_ctl.ask(k, c, v, r, ok);
        if (!ok) begin
            fail_count++;
            end_sim();
        end
    endtask

    task automatic masks(input logic [7:0] s, input logic [7:0] p);
        logic [7:0] r;
        q(3, 3'h1, s, r);
        q(0, 3'h2, 8'h00, r);
        check(r, s);
        q(3, 3'h3, p, r);
        q(0, 3'h4, 8'h00, r);
        check(r, p);
        req_m = s;
        poll_m = p;
    endtask

    // Service requests counted over a fixed window
    task automatic win(output logic [15:0] n);
        logic [15:0] base;
        base = srq_seen;
        repeat (8) @(posedge sys_clk);
        n = srq_seen - base;
    endtask

    // ==========================================
    // Every read path against the expected byte and flag
    task automatic full;
        logic [7:0] r;
        logic [7:0] e;
        repeat (4) @(posedge sys_clk);
        e = exp_byte(req_m);
        q(0, 3'h0, 8'h00, r);
        check(r, e);
        q(1, 3'h0, 8'h00, r);
        check(r, e);
        q(0, 3'h2, 8'h00, r);
        check(r, req_m);
        q(0, 3'h4, 8'h00, r);
        check(r, poll_m);
        q(0, 3'h5, 8'h00, r);
        check(r, {7'h00, |(e & poll_m)});
        q(2, 3'h0, 8'h00, r);
        check(r, {7'h00, |(e & poll_m)});
        check(status_flag, |(e & poll_m));
    endtask

    initial begin
        void'($urandom(32'he893));
        req_m = 8'h00;
        poll_m = 8'h00;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        full();
        masks(8'hbc, 8'h00);
        win(d);
        check(d, 16'h0000);
        outbuf <= 1'b1;
        win(d);
        check(d, 16'h0001);
        full();
        outbuf <= 1'b0;
        masks(8'h43, 8'h40);
        outbuf <= 1'b1;
        win(d);
        check(d, 16'h0000);
        full();
        outbuf <= 1'b0;
        masks(8'h10, 8'h40);
        outbuf <= 1'b1;
        win(d);
        check(d, 16'h0001);
        full();
        outbuf <= 1'b0;
        masks(8'h04, 8'h04);
        errq_ne <= 1'b1;
        win(d);
        check(d, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk);
            errq_push <= 1'b1;
            @(posedge sys_clk);
            errq_push <= 1'b0;
            win(d);
            check(d, 16'h0001);
        end
        full();
        for (int n = 0; n < 40; n++) begin
            @(posedge sys_clk);
            qev <= 16'h0001 << $urandom_range(0, 15);
            qen <= 16'($urandom);
            oev <= 16'h0001 << $urandom_range(0, 15);
            oen <= 16'($urandom);
            esr <= 8'($urandom);
            ese <= 8'($urandom) & 8'($urandom);
            errq_ne <= 1'($urandom);
            outbuf <= 1'($urandom);
            masks(8'($urandom), 8'($urandom));
            full();
        end
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        req_m = 8'h00;
        poll_m = 8'h00;
        full();
        end_sim();
    end
endmodule
